// >>> design/adc_seq_pkg.sv
// Purpose: Shared constants and types for the conversion sequencer.
// Assumes: 20 MHz mclk; Avalon-MM slave with 32-bit words.
// Notes:   Control bit positions follow the converter control layout.
package adc_seq_pkg;

  // Register map, byte addresses.
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] RESULT_ADDR = 4'h4;
  localparam logic [3:0] POWER_ADDR  = 4'h8;

  // Control field positions.
  localparam int BUSY_BIT   = 0;
  localparam int PSC_LO     = 1;
  localparam int PSC_HI     = 2;
  localparam int MODE_LO    = 3;
  localparam int MODE_HI    = 4;
  localparam int CHAN_LO    = 5;
  localparam int CHAN_HI    = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Prescale codes and half periods in mclk cycles.
  localparam logic [1:0] PSC_DIV2  = 2'h0;
  localparam logic [1:0] PSC_DIV4  = 2'h1;
  localparam logic [1:0] PSC_DIV6  = 2'h2;
  localparam logic [1:0] PSC_DIV12 = 2'h3;
  localparam logic [3:0] HALF_DIV2  = 4'h1;
  localparam logic [3:0] HALF_DIV4  = 4'h2;
  localparam logic [3:0] HALF_DIV6  = 4'h3;
  localparam logic [3:0] HALF_DIV12 = 4'h6;

  // Sequence lengths in converter clock cycles.
  localparam logic [3:0] SAMPLE_CYCLES  = 4'h7;
  localparam logic [3:0] CONVERT_CYCLES = 4'h8;
  localparam logic [3:0] ONE_CYCLE      = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RESET   = 3'b001,
    ST_SAMPLE  = 3'b011,
    ST_CONVERT = 3'b010,
    ST_LOAD    = 3'b110,
    ST_DONE    = 3'b111
  } seq_state_t;

  typedef struct packed {
    logic       powerUp;
    logic       convClk;
    logic       sample;
    logic       loadResult;
    logic [2:0] channelPos;
    logic [2:0] channelNeg;
    logic       differential;
  } core_ctrl_t;

  typedef struct packed {
    seq_state_t state;
    logic [7:0] control;
    logic [7:0] result;
    logic [3:0] divCount;
    logic       convClk;
    logic [3:0] phaseCount;
    logic       halted;
    logic       resumePending;
    logic       resultStale;
    logic       busyClearDue;
    logic       readPending;
    logic [7:0] readData;
  } seq_regs_t;

endpackage

// >>> design/adc_conversion_sequencer.sv
// Purpose: Control sequencer for an eight-channel successive
//          approximation converter, reached over Avalon-MM.
// Assumes: The core presents its result on coreResult during the
//          load cycle; haltReq is a level from the power manager.
// Notes:   Reads answer one cycle after the request, writes at once.
//
// How it works
// - Prescale code picks divide by 2, 4, 6, 12.
// - Converter clock comes from dividing mclk.
// - Busy zero stops divider and converter clock.
// - Busy set powers up and starts conversion.
// - Sample high seven cycles from first fall.
// - Sequence is sample, convert, load; reset only between continuous runs.
// - Single mode completion powers down, clears busy.
// - Continuous mode deselects one cycle, then restarts.
// - Busy stays set; writing zero stops conversion.
// - Result register loads at end of conversion.
// - Reads never see a half-written result.
// - While busy, only busy bit is writable.
// - Idle write may load fields and start.
// - Result register ignores processor writes.
// - Halt powers down; restart, result invalid.
// - Mode bits select ended/differential, single/continuous.
// - Channel bits pick input; differential pairs neighbours.
// - Reset clears control and powers down.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Power management.
  input  wire logic        haltReq,
  // Converter core.
  input  wire logic [7:0]  coreResult,
  output core_ctrl_t       coreCtrl
);

  seq_regs_t r;
  seq_regs_t next_r;

  function automatic logic [3:0] halfPeriod(input logic [1:0] code);
    unique case (code)
      PSC_DIV2:  halfPeriod = HALF_DIV2;
      PSC_DIV4:  halfPeriod = HALF_DIV4;
      PSC_DIV6:  halfPeriod = HALF_DIV6;
      PSC_DIV12: halfPeriod = HALF_DIV12;
    endcase
  endfunction

  logic       busy;
  logic       continuous;
  logic       fallTick;
  logic       ctrlWrite;
  logic [7:0] wrByte;

  assign busy       = r.control[BUSY_BIT];
  assign continuous = r.control[MODE_LO];
  assign ctrlWrite  = write && address == CTRL_ADDR && byteenable[0];
  assign wrByte     = writedata[7:0];

  // A falling edge of the converter clock is due this cycle.
  assign fallTick = busy && !r.halted && r.convClk &&
                    r.divCount == halfPeriod(r.control[PSC_HI:PSC_LO]) -
                    ONE_CYCLE;

  always_comb
  begin
    next_r = r;
    next_r.readPending = 1'b0;

    // Divider runs only while busy and awake.
    if (!busy || r.halted)
    begin
      next_r.divCount = '0;
      next_r.convClk  = 1'b0;
    end
    else if (r.divCount ==
             halfPeriod(r.control[PSC_HI:PSC_LO]) - ONE_CYCLE)
    begin
      next_r.divCount = '0;
      next_r.convClk  = !r.convClk;
    end
    else
    begin
      next_r.divCount = r.divCount + 4'h1;
    end

    // Sequencer steps on each converter clock falling edge.
    if (fallTick)
    begin
      unique case (r.state)
        ST_IDLE:
        begin
          next_r.state      = ST_SAMPLE;
          next_r.phaseCount = ONE_CYCLE;
        end
        ST_RESET:
        begin
          next_r.state      = ST_SAMPLE;
          next_r.phaseCount = ONE_CYCLE;
        end
        ST_SAMPLE:
        begin
          if (r.phaseCount == SAMPLE_CYCLES)
          begin
            next_r.state      = ST_CONVERT;
            next_r.phaseCount = ONE_CYCLE;
          end
          else
          begin
            next_r.phaseCount = r.phaseCount + 4'h1;
          end
        end
        ST_CONVERT:
        begin
          if (r.phaseCount == CONVERT_CYCLES)
            next_r.state = ST_LOAD;
          else
            next_r.phaseCount = r.phaseCount + 4'h1;
        end
        ST_LOAD:
        begin
          // A halted run sampled a corrupted level; drop its value.
          if (!r.resultStale)
            next_r.result = coreResult;
          next_r.resultStale = 1'b0;
          if (continuous)
            next_r.state = ST_RESET;
          else
          begin
            next_r.state        = ST_DONE;
            next_r.busyClearDue = 1'b1;
          end
        end
        ST_DONE:
        begin
          next_r.state = ST_DONE;
        end
      endcase
    end

    // Busy clears one mclk later, on the instruction boundary.
    if (r.busyClearDue)
    begin
      next_r.control[BUSY_BIT] = 1'b0;
      next_r.busyClearDue      = 1'b0;
      next_r.state             = ST_IDLE;
    end

    // Halt powers down; a running conversion restarts on wake.
    if (haltReq && !r.halted)
    begin
      next_r.halted = 1'b1;
      if (busy && r.state != ST_IDLE)
        next_r.resumePending = 1'b1;
    end
    else if (!haltReq && r.halted)
    begin
      next_r.halted = 1'b0;
      if (r.resumePending)
      begin
        next_r.state         = ST_IDLE;
        next_r.phaseCount    = '0;
        next_r.resultStale   = 1'b1;
        next_r.resumePending = 1'b0;
      end
    end

    // Processor write to control.
    if (ctrlWrite)
    begin
      if (busy)
      begin
        next_r.control[BUSY_BIT] = wrByte[BUSY_BIT];
        if (!wrByte[BUSY_BIT])
        begin
          next_r.state         = ST_IDLE;
          next_r.busyClearDue  = 1'b0;
          next_r.resumePending = 1'b0;
          next_r.resultStale   = 1'b0;
        end
      end
      else
      begin
        next_r.control      = wrByte;
        next_r.state        = ST_IDLE;
        next_r.phaseCount   = '0;
        next_r.busyClearDue = 1'b0;
      end
    end

    // Read data is latched from settled registers, never mid-load.
    if (read && !r.readPending)
    begin
      next_r.readPending = 1'b1;
      unique case (address)
        CTRL_ADDR:   next_r.readData = r.control;
        RESULT_ADDR: next_r.readData = r.result;
        POWER_ADDR:  next_r.readData = {5'h00, r.halted,
                                        r.state == ST_SAMPLE,
                                        busy && !r.halted};
        default:     next_r.readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r         <= '0;
      r.state   <= ST_IDLE;
      r.control <= CTRL_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign waitrequest = read && !r.readPending;
  assign readdata    = {24'h000000, r.readData};

  always_comb
  begin
    coreCtrl              = '0;
    coreCtrl.powerUp      = busy && !r.halted;
    coreCtrl.convClk      = r.convClk;
    coreCtrl.sample       = r.state == ST_SAMPLE && !r.halted;
    coreCtrl.loadResult   = r.state == ST_LOAD;
    coreCtrl.differential = r.control[MODE_HI];
    coreCtrl.channelPos   = r.control[CHAN_HI:CHAN_LO];
    coreCtrl.channelNeg   = r.control[CHAN_HI:CHAN_LO] ^ 3'h1;
  end

  // Assertions.
  a_clock_stopped: assert property (@(posedge mclk) disable iff (rst)
    !busy |=> !r.convClk)
    else $error("Converter clock ran while idle.");

  a_sample_length: assert property (@(posedge mclk) disable iff (rst)
    $rose(r.state == ST_SAMPLE) && r.control[PSC_HI:PSC_LO] == PSC_DIV2
    && !haltReq && !ctrlWrite
    |-> (r.state == ST_SAMPLE || !busy || r.halted)[*8])
    else $error("Sample period too short.");

  a_busy_clears: assert property (@(posedge mclk) disable iff (rst)
    r.busyClearDue && !ctrlWrite |=> !busy)
    else $error("Busy not cleared after single conversion.");

  a_cont_restart: assert property (@(posedge mclk) disable iff (rst)
    fallTick && r.state == ST_LOAD && continuous && !ctrlWrite
    && !(haltReq ^ r.halted) |=> r.state == ST_RESET)
    else $error("Continuous mode did not deselect.");

  a_ctrl_locked: assert property (@(posedge mclk) disable iff (rst)
    busy && ctrlWrite |=>
    r.control[CHAN_HI:PSC_LO] == $past(r.control[CHAN_HI:PSC_LO]))
    else $error("Control field changed while busy.");

  a_stop_write: assert property (@(posedge mclk) disable iff (rst)
    busy && ctrlWrite && !wrByte[BUSY_BIT] |=> !busy ##1 !r.convClk)
    else $error("Stop write did not halt conversion.");

  a_result_hold: assert property (@(posedge mclk) disable iff (rst)
    !(fallTick && r.state == ST_LOAD) |=> $stable(r.result))
    else $error("Result changed outside load cycle.");

  a_halt_power: assert property (@(posedge mclk) disable iff (rst)
    haltReq |=> !coreCtrl.powerUp)
    else $error("Converter powered during halt.");

  a_read_answer: assert property (@(posedge mclk) disable iff (rst)
    read && waitrequest |=> !waitrequest || !read)
    else $error("Read not answered in one cycle.");

endmodule // adc_conversion_sequencer

// >>> tb/adc_core_model.sv
// Purpose: Behavioural converter core facing the sequencer.
// Assumes: Result is latched by the sequencer during its load cycle.
// Notes:   Outside load the bus shows the inverse of the last value.
`timescale 1ns/10ps
module adc_core_model
  import adc_seq_pkg::*;
(
  // Clock.
  input  wire logic       mclk,
  // Sequencer side.
  input  core_ctrl_t      coreCtrl,
  output logic [7:0]      coreResult
);
  logic [7:0] val = 8'h3c;
  logic       prevLoad = 1'b0;

  // A fresh value per conversion, so a missed load is visible.
  always @(posedge mclk)
  begin
    prevLoad <= coreCtrl.loadResult;
    if (coreCtrl.loadResult && !prevLoad)
      val <= val + 8'h27;
  end

  // A released bus must not repeat the last value.
  assign coreResult = coreCtrl.loadResult ? val : ~val;
endmodule // adc_core_model

// >>> tb/test_adc_conversion_sequencer.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Avalon-MM master with waitrequest; 20 MHz mclk.
// Notes:   Sequence lengths are counted in mclk cycles at the core.
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
  logic        mclk = 0, rst = 1, read = 0, write = 0, haltReq = 0;
  logic [3:0]  address = 4'h0, byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, prevLoad = 0;
  logic [7:0]  coreResult, q, lastRes;
  core_ctrl_t  coreCtrl;
  int err_total = 0, num_checks = 0;
  int sampleCyc = 0, loadCyc = 0, loads = 0, s0, l0, n0, half;
  int halves[4] = '{1, 2, 3, 6};
  logic [2:0]  chan;

  always #25 mclk = ~mclk;

  adc_conversion_sequencer u_dut(.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .haltReq(haltReq), .coreResult(coreResult), .coreCtrl(coreCtrl));
  adc_core_model u_core(.mclk(mclk), .coreCtrl(coreCtrl),
    .coreResult(coreResult));

  always @(posedge mclk)
  begin
    if (coreCtrl.sample) sampleCyc++;
    if (coreCtrl.loadResult) loadCyc++;
    if (coreCtrl.loadResult && !prevLoad) loads++;
    prevLoad = coreCtrl.loadResult;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request is held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      report_and_stop;
    end
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, CTRL_ADDR, 8'h00);
      n++;
    end while (q[BUSY_BIT] !== 1'b0 && n < 300);
    if (n >= 300)
    begin
      err_total++;
      report_and_stop;
    end
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, CTRL_ADDR, 8'h00);
    `CHK("ctrl", CTRL_RESET, q)
    `CHK("power", 1'b0, coreCtrl.powerUp)
    // Every prescale code, alternating single-ended and differential.
    // Only divide by 12 keeps the converter in range at this mclk.
    // The faster codes run the same checks as divide by 12, except that divide by 2 and 6 skip neg.
    for (int i = 0; i < 4; i++)
    begin
      half = halves[i];
      chan = 3'(2 * i + 1);
      s0 = sampleCyc;
      l0 = loadCyc;
      bus(1'b1, CTRL_ADDR, {chan, i[0], 1'b0, 2'(i), 1'b1});
      repeat (4) @(posedge mclk);
      `CHK("up", 1'b1, coreCtrl.powerUp)
      `CHK("pos", chan, coreCtrl.channelPos)
      `CHK("diff", i[0], coreCtrl.differential)
      if (i[0]) `CHK("neg", chan ^ 3'h1, coreCtrl.channelNeg)
      wait_idle;
      `CHK("sample", 14 * half, sampleCyc - s0)
      `CHK("load", 2 * half, loadCyc - l0)
      `CHK("clk", 1'b0, coreCtrl.convClk)
      `CHK("down", 1'b0, coreCtrl.powerUp)
      bus(1'b0, RESULT_ADDR, 8'h00);
      `CHK("result", u_core.val, q)
    end
    // Field lock while busy, then stop and restart back to back.
    bus(1'b1, CTRL_ADDR, 8'h07);
    bus(1'b1, CTRL_ADDR, 8'hf9);
    bus(1'b0, CTRL_ADDR, 8'h00);
    `CHK("lock", 8'h07, q)
    lastRes = u_core.val;
    bus(1'b1, CTRL_ADDR, 8'h00);
    bus(1'b1, CTRL_ADDR, 8'h43);
    bus(1'b0, RESULT_ADDR, 8'h00);
    `CHK("keep", lastRes, q)
    bus(1'b0, CTRL_ADDR, 8'h00);
    `CHK("new", 8'h43, q)
    wait_idle;
    bus(1'b0, RESULT_ADDR, 8'h00);
    `CHK("result2", u_core.val, q)
    // Differential continuous scan, stopped by software.
    n0 = loads;
    bus(1'b1, CTRL_ADDR, 8'h19);
    for (int k = 0; k < 400 && loads < n0 + 2; k++) @(posedge mclk);
    `CHK("cont", 1'b1, loads >= n0 + 2)
    `CHK("cdiff", 1'b1, coreCtrl.differential)
    bus(1'b0, CTRL_ADDR, 8'h00);
    `CHK("busy", 8'h19, q)
    bus(1'b1, CTRL_ADDR, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK("stopclk", 1'b0, coreCtrl.convClk)
    `CHK("stopup", 1'b0, coreCtrl.powerUp)
    // Result is read-only; unmapped reads give zero.
    lastRes = u_core.val;
    bus(1'b1, RESULT_ADDR, ~lastRes);
    bus(1'b0, RESULT_ADDR, 8'h00);
    `CHK("ro", lastRes, q)
    bus(1'b0, 4'hc, 8'h00);
    `CHK("unmapped", 8'h00, q)
    // Halt in mid-sample powers down; the retried result is dropped.
    bus(1'b1, CTRL_ADDR, 8'h01);
    repeat (6) @(posedge mclk);
    haltReq <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK("halt", 1'b0, coreCtrl.powerUp)
    bus(1'b0, POWER_ADDR, 8'h00);
    `CHK("status", 8'h06, q)
    haltReq <= 1'b0;
    wait_idle;
    bus(1'b0, RESULT_ADDR, 8'h00);
    `CHK("invalid", lastRes, q)
    report_and_stop;
  end
endmodule // test_adc_conversion_sequencer
